// ===== dsp_pkg.sv
// package: register map, field layout, modes and constants of the dual-slope pwm timer
package dsp_pkg;
    // apb register byte offsets
    localparam logic [7:0] DSP_OFF_CTRL_A = 8'h00; // timer_control_a
    localparam logic [7:0] DSP_OFF_CTRL_B = 8'h04; // mode high bits, clock select
    localparam logic [7:0] DSP_OFF_COUNT = 8'h08; // count_value
    localparam logic [7:0] DSP_OFF_CMP_A = 8'h0C; // compare_a_value buffer
    localparam logic [7:0] DSP_OFF_CMP_B = 8'h10; // compare b buffer
    localparam logic [7:0] DSP_OFF_CAPT = 8'h14; // capture_value_reg
    localparam logic [7:0] DSP_OFF_FLAGS = 8'h18; // flags, write one to clear
    localparam logic [7:0] DSP_OFF_STATUS = 8'h1C; // direction and waveform state levels
    // timer_control_a fields
    localparam int DSP_COM_A_LSB = 6;
    localparam int DSP_COM_B_LSB = 4;
    localparam int DSP_WGM_LO_LSB = 0;
    // control b fields
    localparam int DSP_WGM_HI_LSB = 3;
    localparam int DSP_CS_LSB = 0;
    // flag register bits
    localparam int DSP_FLAG_OVF = 0;
    localparam int DSP_FLAG_MA = 1;
    localparam int DSP_FLAG_MB = 2;
    localparam int DSP_FLAG_CAP = 3;
    // reset values, count bottom and count maximum
    localparam logic [7:0] DSP_CTRL_RST = 8'h00;
    localparam logic [15:0] DSP_WORD_RST = 16'h0000;
    localparam logic [15:0] DSP_BOTTOM = 16'h0000;
    localparam logic [15:0] DSP_MAX = 16'hFFFF;
    // prescaler divide ratios minus one
    localparam logic [9:0] DSP_DIV8 = 10'h007;
    localparam logic [9:0] DSP_DIV64 = 10'h03F;
    localparam logic [9:0] DSP_DIV256 = 10'h0FF;
    localparam logic [9:0] DSP_DIV1024 = 10'h3FF;

    // clock select codes
    typedef enum logic [2:0] {
        DSP_CS_STOP = 3'h0,
        DSP_CS_1 = 3'h1,
        DSP_CS_8 = 3'h2,
        DSP_CS_64 = 3'h3,
        DSP_CS_256 = 3'h4,
        DSP_CS_1024 = 3'h5
    } dsp_cs_t;

    // output mode field values
    typedef enum logic [1:0] {
        DSP_COM_OFF = 2'h0,
        DSP_COM_TOGGLE = 2'h1,
        DSP_COM_CLEAR = 2'h2,
        DSP_COM_SET = 2'h3
    } dsp_com_t;

    // count direction
    typedef enum logic {
        DSP_DIR_UP = 1'b0,
        DSP_DIR_DOWN = 1'b1
    } dsp_dir_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dsp_apb_req_t;

    // apb answer bundle
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dsp_apb_rsp_t;

    // pin drive bundle for one waveform pin
    typedef struct packed {
        logic level;
        logic oe_n;
    } dsp_pin_t;
endpackage : dsp_pkg

// ===== dsp_prescaler.sv
// prescaler: one-cycle timer_tick enable from the i/o clock
module dsp_prescaler (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // clock select
    input wire logic [2:0] sel_in,
    // tick enable
    output logic tick_out
);
    import dsp_pkg::*;

    logic [9:0] div_reg;
    logic [9:0] limit;

    // divide ratio minus one for the selected rate
    always_comb begin
        case (dsp_cs_t'(sel_in))
            DSP_CS_8: limit = DSP_DIV8;
            DSP_CS_64: limit = DSP_DIV64;
            DSP_CS_256: limit = DSP_DIV256;
            DSP_CS_1024: limit = DSP_DIV1024;
            default: limit = 10'h000;
        endcase
    end

    // free running divider, held at zero when stopped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_reg <= 10'h000;
        end else if (sel_in == DSP_CS_STOP || div_reg >= limit) begin
            div_reg <= 10'h000;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    // tick is a clock enable, not a clock (see [RULE18]) (see [RULE19])
    assign tick_out = (sel_in != DSP_CS_STOP) && (div_reg >= limit);
endmodule : dsp_prescaler

// ===== dsp_timer.sv
// top: 16-bit dual-slope pwm timer with apb registers and two waveform pins
// Overview of operation
// [RULE1] modes 8 and 9 count 0 up to limit, down to 0, forever
// [RULE2] limit is capture register in mode 8, compare a in mode 9
// [RULE3] counter stays at limit one tick, then counts down
// [RULE4] software keeps limit at least 0x0003, up to 0xFFFF
// [RULE5] non-inverting clears on up match, sets on down match; inverting opposite
// [RULE6] output mode 2 is non-inverted, 3 inverted in dual slope
// [RULE7] compare buffers load at bottom, overflow flag set same tick
// [RULE8] limit source flag (a or capture) set when counter reaches limit
// [RULE9] channel flag set whenever counter equals its active compare value
// [RULE10] software keeps limit not below compares; above-limit compare never matches
// [RULE11] compare zero gives low, compare at limit high; inverted opposite
// [RULE12] mode 9 with channel a mode 1 toggles a each match
// [RULE13] nonzero output mode field hands pin to the waveform; here mode 01 in pwm modes keeps the port except channel a in modes 9 and 15
// [RULE14] software must set pin direction to output for waveform to drive
// [RULE15] non-pwm: 00 off, 01 toggle, 10 low, 11 high on match
// [RULE16] fast pwm: 10 clear match set bottom, 11 opposite, 01 toggle a mode 15
// [RULE17] control a: channel a mode 7:6, channel b 5:4, resets zero
// [RULE18] all logic on i/o clock, tick is a clock enable
// [RULE19] prescaler divides by 1, 8, 64, 256 or 1024
// [RULE20] dual slope mode 01 toggles a only in modes 9 or 14
// [RULE21] mode field low bits in control a 1:0, high bits in control b
// [RULE22] waveform state registers reset low
//
// The register offsets and the APB register port are this design's own decisions.
module dsp_timer (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // apb slave
    input wire dsp_pkg::dsp_apb_req_t apb_in,
    output dsp_pkg::dsp_apb_rsp_t apb_out,
    // port function for the two pins when not overridden
    input wire logic port_a_level_in,
    input wire logic port_b_level_in,
    input wire logic port_a_dir_in,
    input wire logic port_b_dir_in,
    // pin drive: level and active-low output enable
    output dsp_pkg::dsp_pin_t pin_a_out,
    output dsp_pkg::dsp_pin_t pin_b_out
);
    import dsp_pkg::*;

    // registers
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [15:0] count_value_reg;
    logic [15:0] cmp_a_buf_reg;
    logic [15:0] cmp_b_buf_reg;
    logic [15:0] cmp_a_act_reg;
    logic [15:0] cmp_b_act_reg;
    logic [15:0] capture_value_reg;
    logic [3:0] flags_reg;
    logic dir_reg;
    logic wave_a_reg;
    logic wave_b_reg;
    logic [31:0] rdata_reg;
    logic bot_pend_reg;
    // decoded values
    logic timer_tick;
    logic [3:0] waveform_mode_field;
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic mode_dual_pfc;
    logic mode_dual;
    logic mode_fast;
    logic [15:0] limit;
    logic at_limit;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic wr_en;
    logic rd_en;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic wave_a_next;
    logic wave_b_next;
    logic [15:0] count_next;
    logic dir_next;
    logic bottom_tick;
    logic limit_tick;
    logic slope_down;

    // field split of mode and output mode (see [RULE21]) (see [RULE17])
    assign waveform_mode_field = {ctrl_b_reg[DSP_WGM_HI_LSB +: 2], ctrl_a_reg[DSP_WGM_LO_LSB +: 2]};
    assign output_mode_a = ctrl_a_reg[DSP_COM_A_LSB +: 2];
    assign output_mode_b = ctrl_a_reg[DSP_COM_B_LSB +: 2];

    // mode classes
    assign mode_dual_pfc = (waveform_mode_field == 4'h8) || (waveform_mode_field == 4'h9);
    assign mode_dual = mode_dual_pfc || (waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'hA, 4'hB});
    assign mode_fast = waveform_mode_field inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};

    // period limit source (see [RULE2])
    assign limit = (waveform_mode_field == 4'h8) ? capture_value_reg :
                   (waveform_mode_field == 4'h9) ? cmp_a_act_reg : DSP_MAX;

    // tick source
    dsp_prescaler u_presc (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .sel_in(ctrl_b_reg[DSP_CS_LSB +: 3]),
        .tick_out(timer_tick)
    );

    // compare events on the current count; only equality, so a compare above limit never fires
    assign at_limit = (count_value_reg == limit);
    assign at_bottom = (count_value_reg == DSP_BOTTOM);
    assign match_a = timer_tick && (count_value_reg == cmp_a_act_reg); // see [RULE9]
    assign match_b = timer_tick && (count_value_reg == cmp_b_act_reg); // see [RULE10]

    // apb decode, zero wait states
    assign wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign rd_en = apb_in.psel && !apb_in.penable && !apb_in.pwrite;

    // write strobe for one register offset
    function automatic logic reg_hit(input logic [7:0] off);
        return wr_en && (apb_in.paddr == off);
    endfunction : reg_hit

    // tick-qualified end points; a match at limit counts as falling, at bottom as rising
    assign bottom_tick = timer_tick && at_bottom;
    assign limit_tick = timer_tick && at_limit;
    assign slope_down = !at_bottom && (at_limit || dir_reg == DSP_DIR_DOWN); // see [RULE11]

    // counter next state: modes 8 and 9 up to limit, hold one tick, down to bottom; other modes count up and wrap
    always_comb begin
        count_next = count_value_reg;
        dir_next = dir_reg;
        if (mode_dual_pfc) begin
            if (dir_reg == DSP_DIR_UP) begin
                if (at_limit) begin
                    dir_next = DSP_DIR_DOWN; // see [RULE3]
                    count_next = count_value_reg - 16'h0001;
                end else begin
                    count_next = count_value_reg + 16'h0001; // see [RULE1]
                end
            end else if (at_bottom) begin
                dir_next = DSP_DIR_UP;
                count_next = count_value_reg + 16'h0001;
            end else begin
                count_next = count_value_reg - 16'h0001;
            end
        end else begin
            dir_next = DSP_DIR_UP;
            count_next = count_value_reg + 16'h0001;
        end
    end

    // count value, software write takes priority
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_value_reg <= DSP_WORD_RST;
            dir_reg <= DSP_DIR_UP;
        end else if (reg_hit(DSP_OFF_COUNT)) begin
            count_value_reg <= apb_in.pwdata[15:0];
        end else if (timer_tick) begin
            count_value_reg <= count_next;
            dir_reg <= dir_next;
        end
    end

    // compare buffers written by software
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmp_a_buf_reg <= DSP_WORD_RST;
            cmp_b_buf_reg <= DSP_WORD_RST;
        end else if (wr_en) begin
            if (apb_in.paddr == DSP_OFF_CMP_A) begin
                cmp_a_buf_reg <= apb_in.pwdata[15:0];
            end
            if (apb_in.paddr == DSP_OFF_CMP_B) begin
                cmp_b_buf_reg <= apb_in.pwdata[15:0];
            end
        end
    end

    // active compares load at bottom in modes 8 and 9, immediately otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmp_a_act_reg <= DSP_WORD_RST;
            cmp_b_act_reg <= DSP_WORD_RST;
        end else if (!mode_dual_pfc || bottom_tick) begin
            cmp_a_act_reg <= cmp_a_buf_reg; // see [RULE7]
            cmp_b_act_reg <= cmp_b_buf_reg;
        end
    end

    // capture register written by software
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            capture_value_reg <= DSP_WORD_RST;
        end else if (reg_hit(DSP_OFF_CAPT)) begin
            capture_value_reg <= apb_in.pwdata[15:0];
        end
    end

    // control registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_a_reg <= DSP_CTRL_RST; // see [RULE17]
            ctrl_b_reg <= DSP_CTRL_RST;
        end else if (wr_en) begin
            if (apb_in.paddr == DSP_OFF_CTRL_A) begin
                ctrl_a_reg <= {apb_in.pwdata[7:4], 2'h0, apb_in.pwdata[1:0]};
            end
            if (apb_in.paddr == DSP_OFF_CTRL_B) begin
                ctrl_b_reg <= {3'h0, apb_in.pwdata[4:0]};
            end
        end
    end

    // flag events; set wins over a write-one clear
    always_comb begin
        flag_set = 4'h0;
        flag_set[DSP_FLAG_MA] = match_a; // see [RULE9]
        flag_set[DSP_FLAG_MB] = match_b;
        if (mode_dual_pfc) begin
            flag_set[DSP_FLAG_OVF] = bottom_tick; // see [RULE7]
            if (waveform_mode_field == 4'h8) begin
                flag_set[DSP_FLAG_CAP] = limit_tick; // see [RULE8]
            end else begin
                flag_set[DSP_FLAG_MA] = match_a || limit_tick; // see [RULE8]
            end
        end else begin
            flag_set[DSP_FLAG_OVF] = timer_tick && (count_value_reg == DSP_MAX);
        end
    end

    // write-one clear strobes
    assign flag_clr = reg_hit(DSP_OFF_FLAGS) ? apb_in.pwdata[3:0] : 4'h0;

    // sticky flags
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags_reg <= 4'h0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // one waveform channel's next level for the current mode
    function automatic logic wave_step(input logic cur, input logic [1:0] com, input logic match,
                                       input logic is_a, input logic dn, input logic bot);
        logic r;
        r = cur;
        if (mode_dual) begin
            if (com == DSP_COM_TOGGLE) begin
                if (is_a && match && (waveform_mode_field inside {4'h9, 4'hE})) begin
                    r = ~cur; // see [RULE12] (see [RULE20])
                end
            end else if (com[1] && match) begin
                r = (com == DSP_COM_CLEAR) ? dn : ~dn; // see [RULE5] (see [RULE6]) (see [RULE11])
            end
        end else if (mode_fast) begin
            if (com == DSP_COM_TOGGLE) begin
                if (is_a && match && waveform_mode_field == 4'hF) begin
                    r = ~cur; // see [RULE16]
                end
            end else if (com[1] && match) begin
                r = (com == DSP_COM_SET);
            end else if (com[1] && bot) begin
                r = (com == DSP_COM_CLEAR); // see [RULE16]
            end
        end else if (match) begin
            case (dsp_com_t'(com))
                DSP_COM_TOGGLE: r = ~cur; // see [RULE15]
                DSP_COM_CLEAR: r = 1'b0;
                DSP_COM_SET: r = 1'b1;
                default: r = cur;
            endcase
        end
        return r;
    endfunction : wave_step

    // next levels; down means the count is falling through this tick
    always_comb begin
        wave_a_next = wave_step(wave_a_reg, output_mode_a, match_a, 1'b1, slope_down,
                                bottom_tick);
        wave_b_next = wave_step(wave_b_reg, output_mode_b, match_b, 1'b0, slope_down,
                                bottom_tick);
    end

    // waveform state registers, start low
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wave_a_reg <= 1'b0; // see [RULE22]
            wave_b_reg <= 1'b0;
        end else begin
            wave_a_reg <= wave_a_next;
            wave_b_reg <= wave_b_next;
        end
    end

    // whether a channel owns its pin; mode 01 in pwm modes leaves the port alone except channel a in modes 9 and 15
    function automatic logic wave_connected(input logic [1:0] com, input logic is_a);
        logic c;
        c = (com != DSP_COM_OFF);
        if (com == DSP_COM_TOGGLE && (mode_dual || mode_fast)) begin
            c = is_a && (waveform_mode_field inside {4'h9, 4'hF}); // see [RULE20] (see [RULE16])
        end
        return c;
    endfunction : wave_connected

    // pin override when the waveform owns the pin; enable follows port direction
    always_comb begin
        pin_a_out.level = wave_connected(output_mode_a, 1'b1) ? wave_a_reg : port_a_level_in; // see [RULE13]
        pin_b_out.level = wave_connected(output_mode_b, 1'b0) ? wave_b_reg : port_b_level_in;
        pin_a_out.oe_n = ~port_a_dir_in; // see [RULE14]
        pin_b_out.oe_n = ~port_b_dir_in;
    end

    // read data captured in setup cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            case (apb_in.paddr)
                DSP_OFF_CTRL_A: rdata_reg <= {24'h000000, ctrl_a_reg};
                DSP_OFF_CTRL_B: rdata_reg <= {24'h000000, ctrl_b_reg};
                DSP_OFF_COUNT: rdata_reg <= {16'h0000, count_value_reg};
                DSP_OFF_CMP_A: rdata_reg <= {16'h0000, cmp_a_buf_reg};
                DSP_OFF_CMP_B: rdata_reg <= {16'h0000, cmp_b_buf_reg};
                DSP_OFF_CAPT: rdata_reg <= {16'h0000, capture_value_reg};
                DSP_OFF_FLAGS: rdata_reg <= {28'h0000000, flags_reg};
                DSP_OFF_STATUS: rdata_reg <= {29'h00000000, wave_b_reg, wave_a_reg, dir_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // unmapped flag for the access phase
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bot_pend_reg <= 1'b0;
        end else if (apb_in.psel && !apb_in.penable) begin
            bot_pend_reg <= (apb_in.paddr[1:0] != 2'h0) || (apb_in.paddr > DSP_OFF_STATUS);
        end
    end

    // apb answer: always ready, error on unmapped
    always_comb begin
        apb_out.pready = 1'b1;
        apb_out.pslverr = apb_in.psel && apb_in.penable && bot_pend_reg;
        apb_out.prdata = rdata_reg;
    end
endmodule : dsp_timer

// ===== dsp_timer_checker.sv
// checker: port-level assertions for the dual-slope pwm timer
module dsp_timer_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // apb slave side
    input wire dsp_pkg::dsp_apb_req_t apb_in,
    input wire dsp_pkg::dsp_apb_rsp_t apb_out,
    // port function
    input wire logic port_a_level_in,
    input wire logic port_b_level_in,
    input wire logic port_a_dir_in,
    input wire logic port_b_dir_in,
    // pins
    input wire dsp_pkg::dsp_pin_t pin_a_out,
    input wire dsp_pkg::dsp_pin_t pin_b_out
);
    import dsp_pkg::*;
    logic [7:0] ctrl_a_reg;
    logic access;
    logic setup_rd;
    logic bad_addr;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // decode of the current bus cycle
    assign access = apb_in.psel && apb_in.penable;
    assign setup_rd = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
    assign bad_addr = (apb_in.paddr > DSP_OFF_STATUS) || (apb_in.paddr[1:0] != 2'h0);
    // shadow of control a, unused bits read zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_a_reg <= DSP_CTRL_RST;
        end else if (access && apb_in.pwrite && !bad_addr && apb_in.paddr == DSP_OFF_CTRL_A) begin
            ctrl_a_reg <= apb_in.pwdata[7:0] & 8'hF3;
        end
    end
    ready_always_a: assert property (apb_out.pready) else $error("pready low");
    refuse_bad_a: assert property (access && bad_addr |-> apb_out.pslverr) else $error("no slverr");
    accept_good_a: assert property (access && !bad_addr |-> !apb_out.pslverr) else $error("false slverr");
    refused_zero_a: assert property (setup_rd && bad_addr |=> apb_out.prdata == 32'h0)
        else $error("refused read not zero");
    upper_zero_a: assert property (access && !apb_in.pwrite |-> apb_out.prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    ctrl_read_a: assert property (setup_rd && apb_in.paddr == DSP_OFF_CTRL_A
        |=> apb_out.prdata == {24'h0, ctrl_a_reg}) else $error("control a readback wrong");
    port_a_pass_a: assert property (ctrl_a_reg[7:6] == 2'h0
        |-> pin_a_out.level == port_a_level_in) else $error("pin a not port level");
    port_b_pass_a: assert property (ctrl_a_reg[5:4] == 2'h0
        |-> pin_b_out.level == port_b_level_in) else $error("pin b not port level");
    drive_enable_a: assert property (pin_a_out.oe_n == !port_a_dir_in
        && pin_b_out.oe_n == !port_b_dir_in) else $error("output enable wrong");
endmodule : dsp_timer_checker

bind dsp_timer dsp_timer_checker u_checker (.clk_in(clk_in), .nrst_in(nrst_in), .apb_in(apb_in),
    .apb_out(apb_out), .port_a_level_in(port_a_level_in), .port_b_level_in(port_b_level_in),
    .port_a_dir_in(port_a_dir_in), .port_b_dir_in(port_b_dir_in), .pin_a_out(pin_a_out),
    .pin_b_out(pin_b_out));

// ===== dsp_timer_tb.sv
// testbench: apb sequences and waveform measurements for the dual-slope pwm timer
module dsp_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsp_pkg::*;
    localparam int CYCLE_LIMIT = 70000;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    dsp_apb_req_t apb_in = '0;
    dsp_apb_rsp_t apb_out;
    logic port_a_level_in = 1'b1;
    logic port_b_level_in = 1'b1;
    logic port_a_dir_in = 1'b0;
    logic port_b_dir_in = 1'b0;
    dsp_pin_t pin_a_out;
    dsp_pin_t pin_b_out;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] rd;
    int ha, ra, hb, rb;
    // polarity and extreme compare table: mode, compare b, high cycles of 64
    logic [1:0] pol_com [6] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3};
    logic [15:0] pol_cmp [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0004, 16'h0004};
    int pol_high [6] = '{16, 48, 0, 64, 64, 0};
    int div_tab [6] = '{0, 1, 8, 64, 256, 1024};

    dsp_timer dut (.clk_in(clk_in), .nrst_in(nrst_in), .apb_in(apb_in), .apb_out(apb_out),
        .port_a_level_in(port_a_level_in), .port_b_level_in(port_b_level_in),
        .port_a_dir_in(port_a_dir_in), .port_b_dir_in(port_b_dir_in),
        .pin_a_out(pin_a_out), .pin_b_out(pin_b_out));

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            fail_count++;
            end_sim();
        end
    end

    // compare seen against expected
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer, request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rdat);
        @(posedge clk_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        do @(posedge clk_in); while (apb_out.pready !== 1'b1);
        rdat = apb_out.prdata;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask : xfer

    // high cycles and rising edges of both pins over n cycles
    task automatic measure(input int n, output int ha_o, ra_o, hb_o, rb_o);
        logic pa, pb;
        @(negedge clk_in);
        pa = pin_a_out.level;
        pb = pin_b_out.level;
        ha_o = 0; ra_o = 0; hb_o = 0; rb_o = 0;
        repeat (n) begin
            @(negedge clk_in);
            ha_o += int'(pin_a_out.level === 1'b1);
            hb_o += int'(pin_b_out.level === 1'b1);
            ra_o += int'(!pa && pin_a_out.level === 1'b1);
            rb_o += int'(!pb && pin_b_out.level === 1'b1);
            pa = pin_a_out.level;
            pb = pin_b_out.level;
        end
    endtask : measure

    // main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        xfer(1'b0, DSP_OFF_CTRL_A, 32'h0, rd);
        check("control a reset", rd, 32'h0);
        xfer(1'b0, DSP_OFF_COUNT, 32'h0, rd);
        check("count reset", rd, 32'h0);
        @(negedge clk_in);
        check("pin a port level", {31'h0, pin_a_out.level}, 32'h1);
        xfer(1'b1, DSP_OFF_CTRL_A, 32'hFFFFFFFF, rd);
        xfer(1'b0, DSP_OFF_CTRL_A, 32'h0, rd);
        check("control a fields", rd, 32'hF3);
        @(negedge clk_in);
        check("pin a wave reset", {31'h0, pin_a_out.level}, 32'h0);
        check("pin b wave reset", {31'h0, pin_b_out.level}, 32'h0);
        xfer(1'b0, 8'h20, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        port_a_dir_in <= 1'b1;
        port_b_dir_in <= 1'b1;
        $display("test registers done");
        // mode 9 at every prescaler ratio, limit 4, compare b 2, a toggles at limit
        xfer(1'b1, DSP_OFF_CMP_A, 32'h4, rd);
        xfer(1'b1, DSP_OFF_CMP_B, 32'h2, rd);
        xfer(1'b1, DSP_OFF_CTRL_A, 32'h61, rd);
        for (int cs = 1; cs <= 5; cs++) begin
            xfer(1'b1, DSP_OFF_CTRL_B, {24'h0, 5'h02, 3'(cs)}, rd);
            measure(16 * div_tab[cs], ha, ra, hb, rb);
            measure(16 * div_tab[cs], ha, ra, hb, rb);
            check("pin b high", 32'(hb), 32'(8 * div_tab[cs]));
            check("pin b rises", 32'(rb), 32'h2);
            check("pin a high", 32'(ha), 32'(8 * div_tab[cs]));
            check("pin a rises", 32'(ra), 32'h1);
        end
        xfer(1'b1, DSP_OFF_CTRL_B, 32'h10, rd);
        xfer(1'b0, DSP_OFF_FLAGS, 32'h0, rd);
        check("mode 9 flags", rd, 32'h7);
        xfer(1'b1, DSP_OFF_FLAGS, 32'hF, rd);
        xfer(1'b0, DSP_OFF_FLAGS, 32'h0, rd);
        check("flags cleared", rd, 32'h0);
        $display("test mode 9 done");
        // polarity and extreme compare values
        xfer(1'b1, DSP_OFF_CTRL_B, 32'h11, rd);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, DSP_OFF_CMP_B, {16'h0, pol_cmp[i]}, rd);
            xfer(1'b1, DSP_OFF_CTRL_A, {24'h0, 2'h1, pol_com[i], 4'h1}, rd);
            measure(24, ha, ra, hb, rb);
            measure(64, ha, ra, hb, rb);
            check("polarity high", 32'(hb), 32'(pol_high[i]));
        end
        $display("test polarity done");
        // mode 8, limit 5 from capture, compare a above limit
        xfer(1'b1, DSP_OFF_CAPT, 32'h5, rd);
        xfer(1'b1, DSP_OFF_CMP_B, 32'h1, rd);
        xfer(1'b1, DSP_OFF_CMP_A, 32'h7, rd);
        xfer(1'b1, DSP_OFF_CTRL_A, 32'h20, rd);
        measure(40, ha, ra, hb, rb);
        xfer(1'b1, DSP_OFF_FLAGS, 32'hF, rd);
        measure(60, ha, ra, hb, rb);
        check("mode 8 high", 32'(hb), 32'hC);
        check("mode 8 rises", 32'(rb), 32'h6);
        xfer(1'b1, DSP_OFF_CTRL_B, 32'h10, rd);
        xfer(1'b0, DSP_OFF_FLAGS, 32'h0, rd);
        check("mode 8 flags", rd, 32'hD);
        $display("test mode 8 done");
        // non-pwm set on match, then inverting fast pwm: clear at bottom, set on match
        xfer(1'b1, DSP_OFF_CMP_B, 32'h10, rd);
        xfer(1'b1, DSP_OFF_CTRL_A, 32'h30, rd);
        xfer(1'b1, DSP_OFF_CTRL_B, 32'h01, rd);
        repeat (24) @(negedge clk_in);
        check("non-pwm set", {31'h0, pin_b_out.level}, 32'h1);
        xfer(1'b1, DSP_OFF_CTRL_A, 32'h31, rd);
        xfer(1'b1, DSP_OFF_CTRL_B, 32'h09, rd);
        xfer(1'b1, DSP_OFF_COUNT, 32'hFFFC, rd);
        repeat (8) @(negedge clk_in);
        check("fast pwm bottom", {31'h0, pin_b_out.level}, 32'h0);
        repeat (16) @(negedge clk_in);
        check("fast pwm match", {31'h0, pin_b_out.level}, 32'h1);
        $display("test other modes done");
        end_sim();
    end
endmodule : dsp_timer_tb
